// ==== verilog/fotg_params.svh ====
// Purpose: Timing figures and derived cycle counts for the flash operation timing guard
// Assumes: Controller clock of 100 MHz
// Notes:   Least times round up, longest times round down, never below one cycle
`ifndef FOTG_PARAMS_SVH
`define FOTG_PARAMS_SVH
`define FOTG_CLK_PERIOD_PS         10000
`define FOTG_INIT_READ_NS          200000
`define FOTG_INIT_CCS_NS           500
`define FOTG_PLANE_BUSY_NS         500
`define FOTG_CACHE_BUSY_NS         3000
`define FOTG_VOL_WAIT_NS           50
`define FOTG_CHAIN_IGNORE_NS       15
`define FOTG_CHAIN_OUT_NS          50
`define FOTG_LONG_CAL_NS           1000
`define FOTG_SHORT_CAL_NS          300
`define FOTG_BUSY_ASSERT_NS        100
`define FOTG_FEATURE_NS            1000
`define FOTG_RESET_IDLE_NS         5000
`define FOTG_RESET_PROG_NS         10000
`define FOTG_RESET_ERASE_NS        50000
`define FOTG_UP(ns)   ((((ns) * 1000) + `FOTG_CLK_PERIOD_PS - 1) / `FOTG_CLK_PERIOD_PS)
`define FOTG_DN(ns)   (((((ns) * 1000) / `FOTG_CLK_PERIOD_PS) < 1) ? 1 : (((ns) * 1000) / `FOTG_CLK_PERIOD_PS))
`define FOTG_OP_W                  4
`define FOTG_CNT_W                 24
`endif

// ==== verilog/fotg_pkg.sv ====
// Purpose: Types shared by both ends of the flash operation timing guard
// Assumes: Nothing beyond the params header
// Notes:   Operation codes name the busy interval that follows a command
package fotg_pkg;
  typedef enum logic [3:0] {
    FOTG_OP_READ, FOTG_OP_PROG, FOTG_OP_ERASE, FOTG_OP_RESET,
    FOTG_OP_FEAT, FOTG_OP_ITC, FOTG_OP_PL_READ, FOTG_OP_PL_PROG,
    FOTG_OP_PL_ERASE, FOTG_OP_CACHE_READ, FOTG_OP_CACHE_PROG,
    FOTG_OP_VOL_SEL, FOTG_OP_CAL_LONG, FOTG_OP_CAL_SHORT, FOTG_OP_STATUS
  } fotg_op_t;
endpackage

// ==== verilog/fotg_link_if.sv ====
// Purpose: Link between host controller end and flash target end
// Assumes: One clock, both ends synchronous to it
// Notes:   Ready/busy pin is open drain: level low when target enables drive
`timescale 1ns/1ns
`default_nettype none
interface fotg_link_if;
  logic             cmd_valid;    // One-cycle pulse: final command cycle
  fotg_pkg::fotg_op_t cmd_op;     // Operation of the command
  logic             ce_b;         // Chip enable, active low
  logic             chain_in_b;   // Daisy-chain enable into target, active low
  logic             chain_out_b;  // Daisy-chain enable out of target
  logic             rb_oe;        // Target pulls ready/busy low
  logic             status_ready_bit; // Status bit 6, high when ready
  modport host   (output cmd_valid, cmd_op, ce_b, chain_in_b,
                  input  chain_out_b, rb_oe, status_ready_bit);
  modport target (input  cmd_valid, cmd_op, ce_b, chain_in_b,
                  output chain_out_b, rb_oe, status_ready_bit);
endinterface
`default_nettype wire

// ==== verilog/fotg_wait_cnt.sv ====
// Purpose: Loadable down-counter used for every host wait and target busy interval
// Assumes: Load wins over counting
// Notes:   Done is high while the count is zero
`timescale 1ns/1ns
`default_nettype none
module fotg_wait_cnt #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Load side
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // State
  output logic              done
);
  logic [W-1:0] cnt_reg;  // Cycles left

  // Count down to zero, reload on request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

// ==== verilog/fotg_target.sv ====
// Purpose: Flash target end: busy intervals, status bit 6 and daisy chain
// Assumes: Host keeps its waits; commands are single-cycle pulses
// Notes:   Read, program and erase busy times are parameters so a bench can shorten them
`timescale 1ns/1ns
`default_nettype none
`include "fotg_params.svh"
module fotg_target #(
  parameter int CW        = `FOTG_CNT_W,
  parameter int READ_CYC  = `FOTG_UP(`FOTG_INIT_READ_NS),
  parameter int PROG_CYC  = `FOTG_UP(`FOTG_RESET_PROG_NS),
  parameter int ERASE_CYC = `FOTG_UP(`FOTG_RESET_ERASE_NS)
) (
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST_B,
  // Link
  fotg_link_if.target LINK,
  // Status
  output logic      BUSY
);
  localparam int WB_CYC  = `FOTG_DN(`FOTG_BUSY_ASSERT_NS);
  // The load edge and the phase change each use a cycle, so load two less
  // and the ready bit falls within the busy delay of the command cycle
  localparam int WB_LOAD = (WB_CYC > 1) ? WB_CYC - 2 : 0;
  localparam int ENO_CYC = `FOTG_DN(`FOTG_CHAIN_OUT_NS);

  // Operation phases
  typedef enum logic [1:0] {FOTG_T_IDLE, FOTG_T_WB, FOTG_T_BUSY} fotg_tstate_t;
  fotg_tstate_t state_reg;
  logic [CW-1:0] busy_len_reg;   // Length of coming busy
  logic          rst_busy_reg;   // Busy is a reset interval
  logic          array_busy_reg; // Program or erase running
  logic          erase_run_reg;  // Erase running
  logic          sel;            // Target accepts commands
  logic          take;           // Accepted command
  logic          cnt_done;
  logic          cnt_load;
  logic [CW-1:0] cnt_val;
  logic [7:0]    eno_cnt_reg;    // Cycles since chip enable fell
  logic          eno_reg;

  assign sel  = !LINK.chain_in_b && !LINK.ce_b;
  assign take = sel && LINK.cmd_valid;

  // Busy length chosen per operation
  function automatic logic [CW-1:0] op_len(input fotg_pkg::fotg_op_t op, input logic prog, input logic ers);
    logic [CW-1:0] v;
    v = CW'(1);
    case (op)
      fotg_pkg::FOTG_OP_READ:       v = CW'(READ_CYC);
      fotg_pkg::FOTG_OP_PROG:       v = CW'(PROG_CYC);
      fotg_pkg::FOTG_OP_ERASE:      v = CW'(ERASE_CYC);
      fotg_pkg::FOTG_OP_RESET:      v = ers ? CW'(`FOTG_UP(`FOTG_RESET_ERASE_NS)) :
                                        prog ? CW'(`FOTG_UP(`FOTG_RESET_PROG_NS)) :
                                        CW'(`FOTG_UP(`FOTG_RESET_IDLE_NS));
      fotg_pkg::FOTG_OP_FEAT:       v = CW'(`FOTG_UP(`FOTG_FEATURE_NS));
      fotg_pkg::FOTG_OP_ITC:        v = CW'(`FOTG_UP(`FOTG_FEATURE_NS));
      fotg_pkg::FOTG_OP_PL_READ:    v = CW'(`FOTG_UP(`FOTG_PLANE_BUSY_NS));
      fotg_pkg::FOTG_OP_PL_PROG:    v = CW'(`FOTG_UP(`FOTG_PLANE_BUSY_NS));
      fotg_pkg::FOTG_OP_PL_ERASE:   v = CW'(`FOTG_UP(`FOTG_PLANE_BUSY_NS));
      fotg_pkg::FOTG_OP_CACHE_READ: v = CW'(`FOTG_UP(`FOTG_CACHE_BUSY_NS));
      fotg_pkg::FOTG_OP_CACHE_PROG: v = CW'(`FOTG_UP(`FOTG_CACHE_BUSY_NS));
      fotg_pkg::FOTG_OP_CAL_LONG:   v = CW'(`FOTG_DN(`FOTG_LONG_CAL_NS));
      fotg_pkg::FOTG_OP_CAL_SHORT:  v = CW'(`FOTG_DN(`FOTG_SHORT_CAL_NS));
      default:                      v = CW'(1);
    endcase
    return v;
  endfunction

  // Counter loads: busy-assert delay on take, busy length after it
  always_comb begin
    cnt_load = 1'b0;
    cnt_val  = '0;
    // delay from final cycle
    // Busy delay counts from the last command cycle, which for a feature
    // write is the fourth_param_byte cycle; a reset may cut into busy
    if (take && LINK.cmd_op != fotg_pkg::FOTG_OP_STATUS && LINK.cmd_op != fotg_pkg::FOTG_OP_VOL_SEL
        && (state_reg != FOTG_T_BUSY || LINK.cmd_op == fotg_pkg::FOTG_OP_RESET)) begin
      cnt_load = 1'b1;
      cnt_val  = CW'(WB_LOAD);
    end else if (state_reg == FOTG_T_WB && cnt_done) begin
      cnt_load = 1'b1;
      cnt_val  = busy_len_reg - 1'b1;
    end
  end

  fotg_wait_cnt #(.W(CW)) u_cnt (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // Phase sequencing; reset may interrupt a running array operation
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg      <= FOTG_T_IDLE;
      busy_len_reg   <= '0;
      rst_busy_reg   <= 1'b0;
      array_busy_reg <= 1'b0;
      erase_run_reg  <= 1'b0;
    end else begin
      case (state_reg)
        FOTG_T_IDLE, FOTG_T_WB: begin
          if (cnt_load && state_reg == FOTG_T_IDLE || (take && cnt_load && state_reg == FOTG_T_WB)) begin
            state_reg    <= FOTG_T_WB;
            busy_len_reg <= op_len(LINK.cmd_op, array_busy_reg, erase_run_reg);
            rst_busy_reg <= (LINK.cmd_op == fotg_pkg::FOTG_OP_RESET);
            array_busy_reg <= (LINK.cmd_op == fotg_pkg::FOTG_OP_PROG) || (LINK.cmd_op == fotg_pkg::FOTG_OP_ERASE);
            erase_run_reg  <= (LINK.cmd_op == fotg_pkg::FOTG_OP_ERASE);
          end else if (state_reg == FOTG_T_WB && cnt_done) begin
            state_reg <= FOTG_T_BUSY;
          end
        end
        FOTG_T_BUSY: begin
          if (take && LINK.cmd_op == fotg_pkg::FOTG_OP_RESET) begin
            // Reset during array work takes the longer limit
            state_reg    <= FOTG_T_WB;
            busy_len_reg <= op_len(fotg_pkg::FOTG_OP_RESET, array_busy_reg, erase_run_reg);
            rst_busy_reg <= 1'b1;
          end else if (cnt_done) begin
            state_reg      <= FOTG_T_IDLE;
            rst_busy_reg   <= 1'b0;
            array_busy_reg <= 1'b0;
            erase_run_reg  <= 1'b0;
          end
        end
        default: state_reg <= FOTG_T_IDLE;
      endcase
    end
  end

  assign LINK.rb_oe = (state_reg == FOTG_T_BUSY);
  assign LINK.status_ready_bit = (state_reg != FOTG_T_BUSY);
  assign BUSY = (state_reg == FOTG_T_BUSY) && !rst_busy_reg ? 1'b1 : (state_reg == FOTG_T_BUSY);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      eno_cnt_reg <= '0;
      eno_reg     <= 1'b1;
    end else if (LINK.ce_b) begin
      eno_cnt_reg <= '0;
      eno_reg     <= 1'b1;
    end else if (eno_cnt_reg >= 8'(ENO_CYC - 1)) begin
      eno_reg     <= 1'b0;
    end else begin
      eno_cnt_reg <= eno_cnt_reg + 8'h01;
    end
  end
  assign LINK.chain_out_b = eno_reg;
endmodule
`default_nettype wire

// ==== verilog/fotg_host.sv ====
// How it works
// - Host never shortens any required wait
// - Before init use 200us read, 500ns setup
// - After init use parameter page values
// - Reset limit depends on running array operation
// - Ready/busy low for whole reset; a reset during busy releases it for the busy delay first
// - Status bit 6 falls within busy delay
// - No command until busy delay elapses
// - Feature write delay starts at fourth byte
// - Status bit 6 low during feature busy
// - Apply load, turnaround, column setup waits; only the column setup wait is applied here
// - Training waits only for training commands
// - Array times from parameter page; short fixed
// - Multiplane short busy typically 500 ns
// - Cache busy 3us typical, poll then
// - Pin-reduction setup interface follows supply voltage; the host here has no supply voltage input and uses one setup interface
// - Wait 50 ns after volume select
// - Hold chip enable 50 ns after select
// - Target ignores commands soon after chain low; the target here accepts them at once
// - Chain output low soon after enable
// - Calibration done within 1us or 0.3us
// - Shared resistor beyond eight lengthens calibration; CAL_SHARED_MANY is not used, so calibration limits stay fixed
//
// Purpose: Host end: issues commands only when every wait has run out
// Assumes: User keeps USR_REQ until USR_ACK
//          Target answers with the ready bit and the ready/busy pin
// Notes:   Parameter page values arrive on PP_* ports once initialised
//          The host never issues while a wait runs, so one counter suffices
//          Only the ready bit is polled; the ready/busy pin is not read
//          Limitation: a target stuck busy keeps the host polling forever
`timescale 1ns/1ns
`default_nettype none
`include "fotg_params.svh"
module fotg_host #(
  parameter int CW = `FOTG_CNT_W
) (
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RST_B,
  // User request
  input  wire logic          USR_REQ,
  input  wire logic [3:0]    USR_OP,
  input  wire logic          USR_CE_RELEASE,
  output logic               USR_ACK,
  output logic               USR_DONE,
  // Parameter page values in cycles
  input  wire logic          PP_VALID,
  input  wire logic [CW-1:0] PP_READ_CYC,
  input  wire logic [CW-1:0] PP_CCS_CYC,
  input  wire logic          CAL_SHARED_MANY,
  // Link
  fotg_link_if.host          LINK
);
  // Wait lengths in controller cycles, rounded up so no wait is cut short
  localparam int WB_CYC    = `FOTG_UP(`FOTG_BUSY_ASSERT_NS);
  localparam int VOL_CYC   = `FOTG_UP(`FOTG_VOL_WAIT_NS);
  // Typical cache busy figure doubles as the status polling pace
  localparam int POLL_CYC  = `FOTG_UP(`FOTG_CACHE_BUSY_NS);

  // Host phases: IDLE takes a request, WB sits out the busy delay,
  // POLL looks at the ready bit each poll period; HOLD is kept spare
  typedef enum logic [2:0] {FOTG_H_IDLE, FOTG_H_WB, FOTG_H_POLL, FOTG_H_HOLD} fotg_hstate_t;
  fotg_hstate_t state_reg;
  logic          cmd_valid_reg;  // Command pulse
  logic [3:0]    op_reg;         // Latched operation
  logic          ce_b_reg;       // Chip enable drive
  // One shared wait counter: only one wait is ever open at a time
  logic          cnt_load;       // Load a new wait
  logic [CW-1:0] cnt_val;        // Length of the new wait
  logic          cnt_done;       // Current wait has run out
  logic          done_reg;       // Operation finished pulse
  // Page figures chosen by init state
  logic [CW-1:0] rd_cyc;         // Current read wait
  logic [CW-1:0] ccs_cyc;        // Current column setup wait

  // Before the parameter page is in, the safe initial figures apply
  // Limitation: PP_* values are taken as already counted in cycles
  // pre-init read figures
  assign rd_cyc  = PP_VALID ? PP_READ_CYC : CW'(`FOTG_UP(`FOTG_INIT_READ_NS));
  assign ccs_cyc = PP_VALID ? PP_CCS_CYC  : CW'(`FOTG_UP(`FOTG_INIT_CCS_NS));

  // Ack is combinational and only in idle, so a held request is taken once;
  // the user must drop USR_REQ on the cycle after ack
  assign USR_ACK = (state_reg == FOTG_H_IDLE) && USR_REQ;

  // Counter loads for each wait
  // Trade-off: polling at a fixed pace may see ready up to one period
  // late, but a wait is never ended early
  always_comb begin
    cnt_load = 1'b0;
    cnt_val  = '0;
    case (state_reg)
      FOTG_H_IDLE: if (USR_REQ) begin
        // rounded-up load
        // Counter starts on the same edge as the command pulse
        // Volume select has no busy delay, only its own settle wait
        cnt_load = 1'b1;
        cnt_val  = (USR_OP == 4'(fotg_pkg::FOTG_OP_VOL_SEL)) ? CW'(VOL_CYC) : CW'(WB_CYC);
      end
      FOTG_H_WB: if (cnt_done) begin
        // poll interval
        // A read sits out the whole page read time before its first look
        cnt_load = 1'b1;
        cnt_val  = (op_reg == 4'(fotg_pkg::FOTG_OP_READ)) ? rd_cyc : CW'(POLL_CYC);
      end
      FOTG_H_POLL: if (cnt_done && !LINK.status_ready_bit) begin
        // column setup recheck
        // A read still busy is looked at again after one column setup time
        cnt_load = 1'b1;
        cnt_val  = (op_reg == 4'(fotg_pkg::FOTG_OP_READ)) ? ccs_cyc : CW'(POLL_CYC);
      end
      // no training waits
      // Training commands are not decoded, so their waits never load;
      // HOLD and spare codes load nothing either
      default: begin
        cnt_load = 1'b0;
      end
    endcase
  end

  // Shared down-counter; done stays high while it holds zero
  // A load always wins over counting down
  fotg_wait_cnt #(.W(CW)) u_cnt (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // Sequencing: command, busy delay, poll until ready
  // Done is registered so the user sees it for exactly one cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Reset drops both pulses and returns to idle
      state_reg     <= FOTG_H_IDLE;
      cmd_valid_reg <= 1'b0;
      op_reg        <= '0;
      done_reg      <= 1'b0;
    end else begin
      // Pulses drop unless raised below
      cmd_valid_reg <= 1'b0;
      done_reg      <= 1'b0;
      case (state_reg)
        // Take a request and send the one-cycle command
        // USR_OP is latched so the code stays steady on the link
        FOTG_H_IDLE: if (USR_REQ) begin
          cmd_valid_reg <= 1'b1;
          op_reg        <= USR_OP;
          state_reg     <= FOTG_H_WB;
        end
        FOTG_H_WB: if (cnt_done) begin
          // volume select wait
          // Volume select and status leave nothing to poll for
          if (op_reg == 4'(fotg_pkg::FOTG_OP_VOL_SEL) || op_reg == 4'(fotg_pkg::FOTG_OP_STATUS)) begin
            state_reg <= FOTG_H_IDLE;
            done_reg  <= 1'b1;
          end else begin
            // Every other command goes on to poll the ready bit
            state_reg <= FOTG_H_POLL;
          end
        end
        // Finish once a poll sees the ready bit high; while still busy
        // the load process restarts the poll period
        FOTG_H_POLL: if (cnt_done && LINK.status_ready_bit) begin
          state_reg <= FOTG_H_IDLE;
          done_reg  <= 1'b1;
        end
        // Unused phases fall back to idle
        default: state_reg <= FOTG_H_IDLE;
      endcase
    end
  end

  // one interface for setup
  // Chip enable falls with the request and rises only on release in idle,
  // so it never rises inside a volume select settle wait
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ce_b_reg <= 1'b1;
    end else if (USR_REQ && state_reg == FOTG_H_IDLE) begin
      ce_b_reg <= 1'b0;
    // Release is refused while a command pulse is out
    end else if (USR_CE_RELEASE && state_reg == FOTG_H_IDLE && !cmd_valid_reg) begin
      ce_b_reg <= 1'b1;
    end
  end

  // Link outputs come straight from registers, except the chain input, which is tied low
  assign LINK.cmd_valid  = cmd_valid_reg;
  // The link carries the enum, the user side a plain code
  assign LINK.cmd_op     = fotg_pkg::fotg_op_t'(op_reg);
  assign LINK.ce_b       = ce_b_reg;
  // Single package on this link, so the chain input is always enabled
  assign LINK.chain_in_b = 1'b0;
  // Finished pulse straight from its register
  assign USR_DONE        = done_reg;
endmodule
`default_nettype wire

// ==== sim/fotg_link_props.sv ====
// Purpose: Timing checks on the link joining host and target ends
// Assumes: One clock at 100 MHz, reset asynchronous and active low
// Notes:   Cycle bounds are the busy figures rounded to 10 ns cycles
`timescale 1ns/1ns
`default_nettype none
module fotg_link_props (
  // Clock and reset
  input wire logic               REF_CLK,
  input wire logic               RST_B,
  // Link signals
  input wire logic               cmd_valid,
  input wire fotg_pkg::fotg_op_t cmd_op,
  input wire logic               ce_b,
  input wire logic               chain_in_b,
  input wire logic               chain_out_b,
  input wire logic               rb_oe,
  input wire logic               status_ready_bit
);
  // Commands that open a busy interval; status and volume select do not
  logic busy_op;
  logic vol_op;
  assign vol_op  = cmd_valid && (cmd_op == fotg_pkg::FOTG_OP_VOL_SEL);
  assign busy_op = cmd_valid && !vol_op && (cmd_op != fotg_pkg::FOTG_OP_STATUS);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  chk_busy_flag_drop: assert property (busy_op |-> ##[1:10] !status_ready_bit)
    else $error("status bit not low within busy delay");
  chk_cmd_gap_busy: assert property (cmd_valid && !vol_op |=> (!cmd_valid)[*8] ##1 !cmd_valid)
    else $error("command inside busy assert delay");
  chk_vol_cmd_gap: assert property (vol_op |=> (!cmd_valid)[*4])
    else $error("command too soon after volume select");
  chk_vol_ce_hold: assert property (vol_op |=> (!ce_b)[*4])
    else $error("chip enable raised too soon after volume select");
  chk_chain_out_time: assert property ($fell(ce_b) |-> ##[0:5] !chain_out_b)
    else $error("chain enable out late after chip enable");
  chk_rb_status_agree: assert property (rb_oe |-> !status_ready_bit)
    else $error("ready busy pin low while status shows ready");
  chk_cal_long_time: assert property (cmd_valid && cmd_op == fotg_pkg::FOTG_OP_CAL_LONG |->
    ##[1:10] !status_ready_bit ##[1:100] status_ready_bit) else $error("long calibration overran");
  chk_cal_short_time: assert property (cmd_valid && cmd_op == fotg_pkg::FOTG_OP_CAL_SHORT |->
    ##[1:10] !status_ready_bit ##[1:30] status_ready_bit) else $error("short calibration overran");
  chk_reset_idle_time: assert property (cmd_valid && cmd_op == fotg_pkg::FOTG_OP_RESET && status_ready_bit |->
    ##[1:10] rb_oe ##[1:500] !rb_oe) else $error("idle reset overran");
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for both ends of the flash operation timing guard
// Assumes: 100 MHz clock, bench inputs change on the falling edge
// Notes:   A second target on a bench-driven link covers refusals and reset limits
`timescale 1ns/1ns
`default_nettype none
module tb;
  // Shortened array times keep the run brief
  localparam int RD = 400;
  localparam int PG = 600;
  localparam int ER = 800;
  // Clock, reset and host user side
  logic        REF_CLK;
  logic        RST_B;
  logic        usr_req;
  logic [3:0]  usr_op;
  logic        ce_rel;
  logic        pp_valid;
  logic [23:0] pp_read_cyc;
  logic        usr_ack;
  logic        usr_done;
  logic        t2_busy;
  // Bookkeeping
  int          failures;
  int          num_checks;
  int          n;
  // First link joins both ends; second is driven by the bench
  fotg_link_if link ();
  fotg_link_if link2 ();
  fotg_host #(.CW(24)) fotg_host_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .USR_REQ(usr_req), .USR_OP(usr_op),
    .USR_CE_RELEASE(ce_rel), .USR_ACK(usr_ack), .USR_DONE(usr_done), .PP_VALID(pp_valid),
    .PP_READ_CYC(pp_read_cyc), .PP_CCS_CYC(24'h000032), .CAL_SHARED_MANY(1'b0), .LINK(link));
  fotg_target #(.CW(24), .READ_CYC(RD), .PROG_CYC(PG), .ERASE_CYC(ER)) fotg_target_i (.REF_CLK(REF_CLK),
    .RST_B(RST_B), .LINK(link), .BUSY());
  fotg_target #(.CW(24), .READ_CYC(RD), .PROG_CYC(PG), .ERASE_CYC(ER)) fotg_target_i2 (.REF_CLK(REF_CLK),
    .RST_B(RST_B), .LINK(link2), .BUSY(t2_busy));
  fotg_link_props fotg_link_props_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .ce_b(link.ce_b), .chain_in_b(link.chain_in_b), .chain_out_b(link.chain_out_b),
    .rb_oe(link.rb_oe), .status_ready_bit(link.status_ready_bit));
  // Free-running clock
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Ends the run with counts and verdict
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if ((failures == 0) && (num_checks > 0)) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compares a value and counts the outcome
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Signals that the waits can watch
  function automatic logic sig(input int s);
    case (s)
      0: return usr_ack;
      1: return usr_done;
      2: return link2.status_ready_bit;
      3: return link.ce_b;
      default: return link2.rb_oe;
    endcase
  endfunction
  // Bounded wait sampled on the rising edge, before that edge's updates land
  task automatic wait_for(input int s, input logic lvl, input int lim, output int k);
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
      if (k > lim) begin
        failures++;
        $display("[ERR] wait %0d expected %0d seen timeout", s, lvl);
        give_verdict();
      end
    end while (sig(s) !== lvl);
  endtask
  // Host request held until taken, then wait for completion
  task automatic host_op(input fotg_pkg::fotg_op_t op, output int k);
    int d;
    @(negedge REF_CLK);
    usr_op = op;
    usr_req = 1'b1;
    wait_for(0, 1'b1, 50, d);
    @(negedge REF_CLK);
    usr_req = 0;
    wait_for(1, 1'b1, 30000, k);
  endtask
  // One-cycle command on the bench-driven link
  task automatic t2_cmd(input fotg_pkg::fotg_op_t op);
    @(negedge REF_CLK);
    link2.cmd_op = op;
    link2.cmd_valid = 1'b1;
    @(negedge REF_CLK);
    link2.cmd_valid = 1'b0;
  endtask
  // Busy length on the second link; s picks status bit (2) or pin drive (4)
  task automatic t2_busy_len(input fotg_pkg::fotg_op_t op, input int s, input int lim, output int k);
    int d;
    t2_cmd(op);
    wait_for(s, s == 4, 12, d);
    check_val("busy start delay", 1, d <= 10);
    wait_for(s, s != 4, lim, k);
  endtask
  // Main sequence
  initial begin
    RST_B = 1'b0;
    usr_req = 1'b0;
    usr_op = 4'h0;
    ce_rel = 1'b0;
    pp_valid = 1'b0;
    pp_read_cyc = 24'h000190;
    link2.cmd_valid = 1'b0;
    link2.cmd_op = fotg_pkg::FOTG_OP_STATUS;
    link2.ce_b = 1'b1;
    link2.chain_in_b = 1'b1;
    failures = 0;
    num_checks = 0;
    repeat (3) @(negedge REF_CLK);
    check_val("reset state", 32'h1a, 32'({link.cmd_valid, link.ce_b, link.chain_out_b, link.rb_oe,
      link.status_ready_bit, usr_done}));
    repeat (3) @(negedge REF_CLK);
    RST_B = 1'b1;
    $display("test reset done");
    host_op(fotg_pkg::FOTG_OP_READ, n);
    check_val("initial read wait", 1, n >= 20000);
    @(negedge REF_CLK);
    pp_valid = 1'b1;
    host_op(fotg_pkg::FOTG_OP_READ, n);
    check_val("reported read wait", 1, (n >= RD) && (n < 20000));
    $display("test read timing done");
    // Every operation code through both design ends
    for (int i = 0; i < 15; i++) begin
      host_op(fotg_pkg::fotg_op_t'(i), n);
      check_val("op after busy", 1, (i == 11) || (i == 14) || (n > 10));
    end
    @(negedge REF_CLK);
    ce_rel = 1'b1;
    wait_for(3, 1'b1, 20, n);
    check_val("ce_b released", 1, link.ce_b);
    @(negedge REF_CLK);
    ce_rel = 1'b0;
    host_op(fotg_pkg::FOTG_OP_STATUS, n);
    $display("test all ops done");
    // Deselected, chain off, then status op: none may start busy
    for (int i = 0; i < 3; i++) begin
      @(negedge REF_CLK);
      link2.ce_b = (i == 0);
      link2.chain_in_b = (i == 1);
      t2_cmd((i == 2) ? fotg_pkg::FOTG_OP_STATUS : fotg_pkg::FOTG_OP_READ);
      repeat (15) @(posedge REF_CLK);
      check_val("refused cmd idle", 32'h2, 32'({link2.status_ready_bit, t2_busy}));
    end
    check_val("chain out low", 0, link2.chain_out_b);
    $display("test refusals done");
    t2_busy_len(fotg_pkg::FOTG_OP_PL_READ, 2, RD + 20, n);
    check_val("plane read busy", 1, n <= RD);
    // Reset in mid program, then in mid erase, takes the longer limit
    for (int i = 0; i < 2; i++) begin
      t2_cmd((i == 1) ? fotg_pkg::FOTG_OP_ERASE : fotg_pkg::FOTG_OP_PROG);
      repeat (100) @(posedge REF_CLK);
      t2_busy_len(fotg_pkg::FOTG_OP_RESET, 4, 6000, n);
      check_val("reset in array op", 1, (n > 500) && (n <= ((i == 1) ? 5010 : 1010)));
    end
    $display("test second link done");
    give_verdict();
  end
endmodule
`default_nettype wire
